// File: cmask_pkg.sv
// Purpose: constants and carriers for the command transfer mask block
// Assumes: 32-bit register port, one word per register
// Notes:   offsets other than those of the mask register are local choices
package cmask_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          NUM_OBJ       = 32;
  localparam int          OBJ_W         = 5;
  localparam logic [7:0]  OFF_CMASK     = 8'h24;
  localparam logic [7:0]  OFF_MESSAGE_OBJECT_NUMBER      = 8'h20;
  localparam logic [7:0]  OFF_MCTL      = 8'h38;
  localparam logic [7:0]  OFF_DA1       = 8'h3C;
  localparam logic [7:0]  OFF_DA2       = 8'h40;
  localparam logic [7:0]  OFF_DB1       = 8'h44;
  localparam logic [7:0]  OFF_DB2       = 8'h48;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h50;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h54;
  localparam int          BIT_DATA_HI   = 0;
  localparam int          BIT_DATA_LO   = 1;
  localparam int          BIT_NEWSEND   = 2;
  localparam int          BIT_CLRPEND   = 3;
  localparam int          BIT_WRITE_DIR = 7;
  localparam int          MCTL_TXRQ     = 8;
  localparam int          MCTL_PEND     = 13;
  localparam int          MCTL_NEWD     = 15;
  localparam logic [7:0]  CMASK_RST     = 8'h00;
  localparam logic [5:0]  MESSAGE_OBJECT_NUMBER_RST      = 6'h01;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_TX        = 1;

  typedef struct packed {
    logic        write_dir;
    logic        clear_pending_select;
    logic        new_data_or_send_select;
    logic        data_low_select;
    logic        data_high_select;
  } cmask_s;

  typedef struct packed {
    logic        interrupt_pending_flag;
    logic        new_data_flag;
    logic        transmit_request_flag;
    logic [31:0] data_low;
    logic [31:0] data_high;
  } msg_obj_s;
endpackage

// File: can_if_command_mask_low.sv
// Purpose: interface-to-message-object transfer steered by the command mask
// Assumes: one clock; register strobes are one cycle; read data next cycle
// Notes:   transfer runs in the cycle after a message number write
`timescale 1ns/10ps
// What this block does
// - Write: clear-pending 1 clears object pending
// - Read, clear-pending 0: copy pending flag
// - Read, clear-pending 1: clear, report old
// - Write: send select requests transmission
// - Read, send select 0: copy new-data
// - Read, send select 1: clear, report old
// - Data-low select moves bytes 0-3
// - Data-high select moves bytes 4-7
// - Software sets direction and sources
// - Message number picks object 1..32
module can_if_command_mask_low (
  input  wire logic                      clk_sys_i, // 50 MHz system clock
  input  wire logic                      rstn_i,    // Async reset, active low
  input  wire logic [cmask_pkg::ADDR_W-1:0] addr_i, // Register byte address
  input  wire logic [31:0]               wdata_i,   // Write data
  input  wire logic                      wr_i,      // Write strobe
  input  wire logic                      rd_i,      // Read strobe
  output logic      [31:0]               rdata_o,   // Read data, next cycle
  output logic                           irq_o      // Level interrupt
);
  cmask_pkg::cmask_s   cmask, next_cmask;
  logic [5:0]          message_object_number, next_message_object_number;
  logic                go, next_go;
  logic [31:0]         mctl, next_mctl;
  logic [31:0]         da, next_da, db, next_db;
  logic [1:0]          irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [31:0]         next_rdata;
  logic                next_irq;
  cmask_pkg::msg_obj_s obj [cmask_pkg::NUM_OBJ];
  cmask_pkg::msg_obj_s obj_cur, obj_new;
  logic [cmask_pkg::OBJ_W-1:0] idx;
  logic [1:0]          ev;
  localparam logic [1:0] IRQ_CLEAR = cmask_pkg::IRQ_RST;

  // 0 and values above 32 fold back into 1..32 by taking the low bits
  assign idx     = cmask_pkg::OBJ_W'(message_object_number - 6'h01);
  assign obj_cur = obj[idx];

  always_comb begin
    obj_new = obj_cur;
    next_mctl = mctl;
    next_da = da;
    next_db = db;
    ev = 2'h0;
    if (go) begin
      ev[cmask_pkg::IRQ_DONE] = 1'b1;
      if (cmask.write_dir) begin
        if (cmask.clear_pending_select)
          obj_new.interrupt_pending_flag = 1'b0;
        // Send select sets the object's transmit request; the control register's request bit is not copied
        if (cmask.new_data_or_send_select)
          obj_new.transmit_request_flag = 1'b1;
        ev[cmask_pkg::IRQ_TX] = cmask.new_data_or_send_select;
        // Direction as printed: write direction moves object to registers
        if (cmask.data_low_select)
          next_da = obj_cur.data_low;
        if (cmask.data_high_select)
          next_db = obj_cur.data_high;
      end else begin
        next_mctl[cmask_pkg::MCTL_PEND] = obj_cur.interrupt_pending_flag;
        if (cmask.clear_pending_select)
          obj_new.interrupt_pending_flag = 1'b0;
        next_mctl[cmask_pkg::MCTL_NEWD] = obj_cur.new_data_flag;
        if (cmask.new_data_or_send_select)
          obj_new.new_data_flag = 1'b0;
        if (cmask.data_low_select)
          obj_new.data_low = da;
        if (cmask.data_high_select)
          obj_new.data_high = db;
      end
    end
    if (wr_i && addr_i == cmask_pkg::OFF_MCTL)
      next_mctl = wdata_i;
    if (wr_i && addr_i == cmask_pkg::OFF_DA1)
      next_da[15:0] = wdata_i[15:0];
    if (wr_i && addr_i == cmask_pkg::OFF_DA2)
      next_da[31:16] = wdata_i[15:0];
    if (wr_i && addr_i == cmask_pkg::OFF_DB1)
      next_db[15:0] = wdata_i[15:0];
    if (wr_i && addr_i == cmask_pkg::OFF_DB2)
      next_db[31:16] = wdata_i[15:0];
  end

  always_comb begin
    next_cmask = cmask;
    next_message_object_number = message_object_number;
    next_go = 1'b0;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_rdata = cmask_pkg::ZERO_WORD;
    if (wr_i) begin
      case (addr_i)
        cmask_pkg::OFF_CMASK: begin
          next_cmask.write_dir               = wdata_i[cmask_pkg::BIT_WRITE_DIR];
          next_cmask.clear_pending_select    = wdata_i[cmask_pkg::BIT_CLRPEND];
          next_cmask.new_data_or_send_select = wdata_i[cmask_pkg::BIT_NEWSEND];
          next_cmask.data_low_select         = wdata_i[cmask_pkg::BIT_DATA_LO];
          next_cmask.data_high_select        = wdata_i[cmask_pkg::BIT_DATA_HI];
        end
        cmask_pkg::OFF_MESSAGE_OBJECT_NUMBER: begin
          next_message_object_number = wdata_i[5:0];
          next_go   = 1'b1;
        end
        cmask_pkg::OFF_IRQ_MASK: next_irq_mask = wdata_i[1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        cmask_pkg::OFF_CMASK: begin
          next_rdata[cmask_pkg::BIT_WRITE_DIR] = cmask.write_dir;
          next_rdata[cmask_pkg::BIT_CLRPEND]   = cmask.clear_pending_select;
          next_rdata[cmask_pkg::BIT_NEWSEND]   = cmask.new_data_or_send_select;
          next_rdata[cmask_pkg::BIT_DATA_LO]   = cmask.data_low_select;
          next_rdata[cmask_pkg::BIT_DATA_HI]   = cmask.data_high_select;
        end
        cmask_pkg::OFF_MESSAGE_OBJECT_NUMBER:     next_rdata[5:0]  = message_object_number;
        cmask_pkg::OFF_MCTL:     next_rdata       = mctl;
        cmask_pkg::OFF_DA1:      next_rdata[15:0] = da[15:0];
        cmask_pkg::OFF_DA2:      next_rdata[15:0] = da[31:16];
        cmask_pkg::OFF_DB1:      next_rdata[15:0] = db[15:0];
        cmask_pkg::OFF_DB2:      next_rdata[15:0] = db[31:16];
        cmask_pkg::OFF_IRQ_MASK: next_rdata[1:0]  = irq_mask;
        cmask_pkg::OFF_IRQ_STAT: begin
          next_rdata[1:0] = irq_stat;
          next_irq_stat   = IRQ_CLEAR;
        end
        default: ;
      endcase
    end
    // New events win over the read-clear
    next_irq_stat = next_irq_stat | ev;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmask    <= '0;
      message_object_number     <= cmask_pkg::MESSAGE_OBJECT_NUMBER_RST;
      go       <= 1'b0;
      mctl     <= cmask_pkg::ZERO_WORD;
      da       <= cmask_pkg::ZERO_WORD;
      db       <= cmask_pkg::ZERO_WORD;
      irq_stat <= cmask_pkg::IRQ_RST;
      irq_mask <= cmask_pkg::IRQ_RST;
      rdata_o  <= cmask_pkg::ZERO_WORD;
      irq_o    <= 1'b0;
    end else begin
      cmask    <= next_cmask;
      message_object_number     <= next_message_object_number;
      go       <= next_go;
      mctl     <= next_mctl;
      da       <= next_da;
      db       <= next_db;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rdata_o  <= next_rdata;
      irq_o    <= next_irq;
    end
  end

  // Flags start clear, so the first read-back copies known status
  for (genvar g = 0; g < cmask_pkg::NUM_OBJ; g++) begin : g_obj
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i)
        obj[g] <= '0;
      else if (go && idx == cmask_pkg::OBJ_W'(g))
        obj[g] <= obj_new;
    end
  end

  a_reset_selects_zero: assert property (@(posedge clk_sys_i)
    $rose(rstn_i) |-> cmask == '0)
    else $error("selects not zero after reset");

  a_write_clear_pending: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir && cmask.clear_pending_select |=> !obj[$past(idx)].interrupt_pending_flag)
    else $error("pending not cleared on write transfer");

  a_read_copy_pending: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir |=> mctl[cmask_pkg::MCTL_PEND] == $past(obj_cur.interrupt_pending_flag))
    else $error("pending not copied on read");

  a_read_clear_pending: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && cmask.clear_pending_select
      |=> !obj[$past(idx)].interrupt_pending_flag)
    else $error("pending not cleared on read");

  a_send_request: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir && cmask.new_data_or_send_select
      |=> obj[$past(idx)].transmit_request_flag && irq_stat[cmask_pkg::IRQ_TX])
    else $error("send not requested");

  a_read_copy_newdata: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir |=> mctl[cmask_pkg::MCTL_NEWD] == $past(obj_cur.new_data_flag))
    else $error("new data not copied");

  a_read_clear_newdata: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && cmask.new_data_or_send_select |=> !obj[$past(idx)].new_data_flag)
    else $error("new data not cleared");

  a_data_low_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir && cmask.data_low_select && !wr_i |=> da == $past(obj_cur.data_low))
    else $error("data low not loaded");

  a_data_high_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir && cmask.data_high_select && !wr_i |=> db == $past(obj_cur.data_high))
    else $error("data high not loaded");

  a_irq_follows_stat: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    irq_o == |(irq_stat & irq_mask))
    else $error("irq does not match status");

  a_write_keep_pending: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir && !cmask.clear_pending_select
      |=> obj[$past(idx)].interrupt_pending_flag == $past(obj_cur.interrupt_pending_flag))
    else $error("pending changed without clear select");

  a_read_keep_pending: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && !cmask.clear_pending_select
      |=> obj[$past(idx)].interrupt_pending_flag == $past(obj_cur.interrupt_pending_flag))
    else $error("pending changed by plain read");

  a_write_keep_newdata: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir
      |=> obj[$past(idx)].new_data_flag == $past(obj_cur.new_data_flag))
    else $error("new data changed by write transfer");

  a_no_send_keep_req: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !(cmask.write_dir && cmask.new_data_or_send_select)
      |=> obj[$past(idx)].transmit_request_flag == $past(obj_cur.transmit_request_flag))
    else $error("send request changed without send select");

  a_read_keep_newdata: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && !cmask.new_data_or_send_select
      |=> obj[$past(idx)].new_data_flag == $past(obj_cur.new_data_flag))
    else $error("new data changed by plain read");

  a_data_low_store: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && cmask.data_low_select |=> obj[$past(idx)].data_low == $past(da))
    else $error("data low not stored");

  a_data_high_store: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && cmask.data_high_select |=> obj[$past(idx)].data_high == $past(db))
    else $error("data high not stored");

  a_data_low_keep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.data_low_select
      |=> obj[$past(idx)].data_low == $past(obj_cur.data_low))
    else $error("object data low changed");

  a_data_high_keep: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.data_high_select
      |=> obj[$past(idx)].data_high == $past(obj_cur.data_high))
    else $error("object data high changed");

  a_data_low_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !(cmask.write_dir && cmask.data_low_select) && !wr_i |=> da == $past(da))
    else $error("data low register changed");

  a_data_high_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !(cmask.write_dir && cmask.data_high_select) && !wr_i |=> db == $past(db))
    else $error("data high register changed");

  a_write_mctl_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && cmask.write_dir && !wr_i |=> mctl == $past(mctl))
    else $error("control register changed by write transfer");

  a_read_txreq_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go && !cmask.write_dir && !wr_i
      |=> mctl[cmask_pkg::MCTL_TXRQ] == $past(mctl[cmask_pkg::MCTL_TXRQ]))
    else $error("send bit changed by read transfer");

  a_object_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !go |=> obj[$past(idx)] == $past(obj_cur))
    else $error("object changed without transfer");

  a_slot_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    message_object_number[cmask_pkg::OBJ_W-1:0] == '0 |-> idx == '1)
    else $error("number zero not mapped to last object");

  a_slot_direct: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    message_object_number[cmask_pkg::OBJ_W-1:0] != '0 |-> idx == message_object_number[cmask_pkg::OBJ_W-1:0] - 1'b1)
    else $error("object slot mismatch");

  // Number write starts a transfer that ends in the done event
  sequence s_number_write;
    wr_i && addr_i == cmask_pkg::OFF_MESSAGE_OBJECT_NUMBER;
  endsequence

  sequence s_transfer_done;
    go ##1 irq_stat[cmask_pkg::IRQ_DONE];
  endsequence

  a_number_starts_xfer: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_number_write |=> s_transfer_done)
    else $error("number write did not complete a transfer");

  a_go_needs_number: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && addr_i == cmask_pkg::OFF_MESSAGE_OBJECT_NUMBER) |=> !go)
    else $error("transfer without number write");

  a_cmask_load_dir: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == cmask_pkg::OFF_CMASK
      |=> cmask.write_dir == $past(wdata_i[cmask_pkg::BIT_WRITE_DIR]))
    else $error("direction not loaded");

  a_cmask_load_data: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && addr_i == cmask_pkg::OFF_CMASK
      |=> cmask.data_low_select == $past(wdata_i[cmask_pkg::BIT_DATA_LO])
        && cmask.data_high_select == $past(wdata_i[cmask_pkg::BIT_DATA_HI]))
    else $error("data selects not loaded");

  a_cmask_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && addr_i == cmask_pkg::OFF_CMASK) |=> $stable(cmask))
    else $error("command mask changed without write");

  a_status_read_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && addr_i == cmask_pkg::OFF_IRQ_STAT && !go |=> irq_stat == '0)
    else $error("status not cleared by read");

  a_rdata_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data outside read cycle");
endmodule // can_if_command_mask_low

// File: msg_ram_model.sv
// Purpose: reference copy of the message object data behind the block
// Assumes: object data only change through transfers the bench starts
// Notes:   flags are tracked by the bench scenarios, not kept here
`timescale 1ns/10ps
module msg_ram_model;
  logic [31:0] lo [1:32];
  logic [31:0] hi [1:32];
  // Number 0 names object 32; higher codes wrap on five bits
  function automatic int idx(input logic [5:0] n);
    return (n[4:0] == 5'h00) ? 32 : int'(n[4:0]);
  endfunction
endmodule // msg_ram_model

// File: test_can_if_command_mask_low.sv
// Purpose: self-checking bench for the command mask transfer block
// Assumes: message objects get known data before any readback
// Notes:   pending cannot be set from the bus, so old flags read as 0
`timescale 1ns/10ps
module test_can_if_command_mask_low;
  logic        clk_sys_i   = 1'b0;
  logic        rstn_i      = 1'b0;
  logic [7:0]  addr_i      = 8'h00;
  logic [31:0] wdata_i     = 32'h0000_0000;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic [31:0] exp_q[$];
  logic        rd_seen     = 1'b0;
  logic        irq_en      = 1'b1;
  integer      seed        = 32'h3646A88D;
  int          miscompares = 0;
  int          check_count = 0;
  int          k;
  int          j;
  always #10 clk_sys_i = ~clk_sys_i;
  can_if_command_mask_low u_can_if_command_mask_low (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o));
  msg_ram_model u_msg_ram_model ();
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (rd_seen) chk(rdata_o, exp_q.pop_front());
    rd_seen <= rd_i;
  end
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, addr_i, 32'h0000_0000);
  endtask
  task automatic put(input logic [31:0] a, input logic [31:0] b);
    wr(cmask_pkg::OFF_DA1, {16'h0000, a[15:0]});
    wr(cmask_pkg::OFF_DA2, {16'h0000, a[31:16]});
    wr(cmask_pkg::OFF_DB1, {16'h0000, b[15:0]});
    wr(cmask_pkg::OFF_DB2, {16'h0000, b[31:16]});
  endtask
  task automatic get(input logic [31:0] a, input logic [31:0] b);
    rd(cmask_pkg::OFF_DA1, {16'h0000, a[15:0]});
    rd(cmask_pkg::OFF_DA2, {16'h0000, a[31:16]});
    rd(cmask_pkg::OFF_DB1, {16'h0000, b[15:0]});
    rd(cmask_pkg::OFF_DB2, {16'h0000, b[31:16]});
  endtask
  // Each transfer raises the done event, a send request only on write
  task automatic xfer(input logic [7:0] m, input logic [5:0] n);
    wr(cmask_pkg::OFF_CMASK, {24'h000000, m});
    wr(cmask_pkg::OFF_MESSAGE_OBJECT_NUMBER, {26'h0, n});
    idle(2);
    #1 chk({31'h0, irq_o}, {31'h0, irq_en});
    rd(cmask_pkg::OFF_IRQ_STAT, {30'h0, m[7] & m[2], 1'b1});
    idle(2);
    #1 chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(cmask_pkg::OFF_CMASK, 32'h0000_0000);
    rd(cmask_pkg::OFF_MESSAGE_OBJECT_NUMBER, 32'h0000_0001);
    rd(8'hFC, 32'h0000_0000);
    wr(cmask_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    $display("test reset done");
    for (k = 1; k <= 32; k++) begin
      u_msg_ram_model.lo[k] = $random(seed);
      u_msg_ram_model.hi[k] = $random(seed);
      put(u_msg_ram_model.lo[k], u_msg_ram_model.hi[k]);
      xfer(8'h03, k[5:0]);
      xfer(8'h8C, k[5:0]);
    end
    $display("test fill done");
    for (k = 0; k <= 33; k++) begin
      j = u_msg_ram_model.idx(k[5:0]);
      put(32'h0000_0000, 32'h0000_0000);
      xfer(8'h04, k[5:0]);
      wr(cmask_pkg::OFF_MCTL, 32'h0000_A100);
      xfer(8'h08, k[5:0]);
      rd(cmask_pkg::OFF_MCTL, 32'h0000_0100);
      wr(cmask_pkg::OFF_MCTL, 32'h0000_A100);
      xfer(8'h00, k[5:0]);
      rd(cmask_pkg::OFF_MCTL, 32'h0000_0100);
      xfer(8'h82, k[5:0]);
      rd(cmask_pkg::OFF_DB1, 32'h0000_0000);
      xfer(8'h81, k[5:0]);
      get(u_msg_ram_model.lo[j], u_msg_ram_model.hi[j]);
    end
    $display("test readback done");
    irq_en = 1'b0;
    wr(cmask_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    xfer(8'h00, 6'h01);
    $display("test mask done");
    for (k = 0; k < 10 && exp_q.size() > 0; k++) idle(1);
    if (exp_q.size() > 0) miscompares++;
    finish_test();
  end
endmodule // test_can_if_command_mask_low
